// ==== hdl/sgc_global_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Bit 7 of the forwarding options register turns 802.1Q VLAN processing on, and software fills the VLAN table first.
// - With the snoop bit (bit 6) set every IGMP packet is forwarded to the switch MII port, otherwise snooping is off.
// - With weighted fair queuing on and all four queues busy, queues 3:2:1:0 share egress in the ratio 8:4:2:1.
// - Under weighted fair queuing an empty queue gets no share, and while any queue is empty the highest busy queue gains one extra unit.
// - With weighted fair queuing off, scheduling follows the per-port priority method, here strict priority.
// - With the sniff mode bit at 1 a packet is mirrored only when both source and destination ports match.
// - With the sniff mode bit at 0 a packet is mirrored when either source or destination port matches.
// - Bit 6 of the MII/storm register selects half duplex on the switch MII port when set, full duplex when clear.
// - Bit 5 of the MII/storm register enables MII full-duplex flow control and resets to 1.
// - Bit 4 of the MII/storm register runs the MII port at 10 Mbps when set and at 100 Mbps when clear.
// - With null VID replacement enabled a null VLAN ID is replaced by the 12-bit port VID.
// - Each port may pass a programmed number of 64-byte blocks per period of 67 ms at 100 Mbps or 500 ms at 10 Mbps.
// - Bits 2 to 0 of the MII/storm register are threshold bits 10 to 8 and reset to zero.
// - The register at index 0x07 holds threshold bits 7 to 0 and resets to 0x63.
module sgc_global_ctrl #(
	parameter logic [24:0] STORM_PER_100_CYC = sgc_pkg::STORM_PER_100_CYC,
	parameter logic [24:0] STORM_PER_10_CYC  = sgc_pkg::STORM_PER_10_CYC
) (
	// Clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              SYS_RST,
	// AHB-Lite slave
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	// Configuration out
	output sgc_pkg::sgc_cfg_s      CFG,
	// Egress queue scheduling
	input  wire logic [3:0]        Q_NONEMPTY,
	input  wire logic              TX_REQ,
	output logic      [3:0]        TX_GRANT,
	// IGMP snooping
	input  wire logic              IGMP_PKT,
	output logic                   IGMP_TO_MII,
	// Sniffing
	input  wire logic              SNIFF_SRC_HIT,
	input  wire logic              SNIFF_DST_HIT,
	output logic                   SNIFF_MIRROR,
	// VID replacement
	input  wire logic [11:0]       FRM_VID_IN,
	input  wire logic [11:0]       PORT_VID,
	output logic      [11:0]       FRM_VID_OUT,
	// Broadcast storm control
	input  wire logic [2:0]        STORM_BLK_STB,
	output logic      [2:0]        STORM_DROP
);

	// ==========================================================
	// Bus decode
	logic       wr_pend_reg;
	logic [7:0] wr_idx_reg;
	logic       addr_fire;
	logic       mapped;
	logic [7:0] a_idx;
	logic       wr_fwd;
	logic       wr_mii;
	logic       wr_lo;

	assign a_idx     = HADDR[9:2];
	assign mapped    = (HADDR[31:10] == 22'h000000);
	assign addr_fire = HSEL && HREADY && (HTRANS == sgc_pkg::HTRANS_NONSEQ);
	assign wr_fwd    = wr_pend_reg && (wr_idx_reg == sgc_pkg::IDX_FWD_OPT);
	assign wr_mii    = wr_pend_reg && (wr_idx_reg == sgc_pkg::IDX_MII_HIGH);
	assign wr_lo     = wr_pend_reg && (wr_idx_reg == sgc_pkg::IDX_STORM_LO);

	// ==========================================================
	// Registers
	logic [7:0] fwd_reg;
	logic [7:0] mii_reg;
	logic [7:0] lo_reg;
	logic [7:0] fwd_next;
	logic [7:0] mii_next;
	logic [7:0] lo_next;

	// Reserved bits stay zero whatever is written
	assign fwd_next = wr_fwd ? (HWDATA[7:0] & sgc_pkg::WMASK_FWD_OPT) : fwd_reg;
	assign mii_next = wr_mii ? (HWDATA[7:0] & sgc_pkg::WMASK_MII_HIGH) : mii_reg;
	assign lo_next  = wr_lo ? HWDATA[7:0] : lo_reg;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			fwd_reg <= sgc_pkg::RST_FWD_OPT;
			mii_reg <= sgc_pkg::RST_MII_HIGH;
			lo_reg  <= sgc_pkg::RST_STORM_LO;
		end else begin
			fwd_reg <= fwd_next;
			mii_reg <= mii_next;
			lo_reg  <= lo_next;
		end
	end

	assign CFG.vlan_en      = fwd_reg[sgc_pkg::B_VLAN_EN];
	assign CFG.igmp_snoop   = fwd_reg[sgc_pkg::B_IGMP_SNOOP];
	assign CFG.wfq_en       = fwd_reg[sgc_pkg::B_WFQ_EN];
	assign CFG.sniff_and    = fwd_reg[sgc_pkg::B_SNIFF_AND];
	assign CFG.mii_half     = mii_reg[sgc_pkg::B_MII_HALF];
	assign CFG.mii_fc       = mii_reg[sgc_pkg::B_MII_FC];
	assign CFG.mii_10bt     = mii_reg[sgc_pkg::B_MII_10BT];
	assign CFG.null_vid_rep = mii_reg[sgc_pkg::B_NULL_VID];
	assign CFG.storm_thr    = {mii_reg[sgc_pkg::B_THR_HI_MSB:0], lo_reg};

	// ==========================================================
	// Read path, forwarded from the pending write
	logic [7:0]  status_val;
	logic [31:0] rd_next;

	assign status_val = {4'h0, CFG.mii_10bt, STORM_DROP};
	assign rd_next = !mapped ? 32'h00000000 :
		(a_idx == sgc_pkg::IDX_FWD_OPT)  ? {24'h000000, fwd_next} :
		(a_idx == sgc_pkg::IDX_MII_HIGH) ? {24'h000000, mii_next} :
		(a_idx == sgc_pkg::IDX_STORM_LO) ? {24'h000000, lo_next} :
		(a_idx == sgc_pkg::IDX_STATUS)   ? {24'h000000, status_val} : 32'h00000000;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
			HRDATA      <= 32'h00000000;
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
		end else begin
			wr_pend_reg <= addr_fire && HWRITE && mapped;
			wr_idx_reg  <= a_idx;
			HRDATA      <= (addr_fire && !HWRITE) ? rd_next : 32'h00000000;
			HREADYOUT   <= 1'b1;
			HRESP       <= 1'b0;
		end
	end

	// ==========================================================
	// Egress queue scheduler
	logic [3:0] cred_reg [4];
	logic [3:0] cred_next [4];
	logic [3:0] eff_cred [4];
	logic [3:0] cur_elig;
	logic [3:0] elig;
	logic [3:0] pick;
	logic [3:0] grant;
	logic [3:0] hi_ne;
	logic       need_reload;
	logic       any_empty;

	assign any_empty   = !(&Q_NONEMPTY);
	assign need_reload = CFG.wfq_en && !(|cur_elig);
	assign pick        = CFG.wfq_en ? elig : Q_NONEMPTY;

	for (genvar q = 0; q < 4; q++) begin : g_elig
		assign cur_elig[q] = Q_NONEMPTY[q] && (cred_reg[q] != 4'h0);
	end

	// Weights and eligibility apart from the pick, so no process reads what it writes
	always_comb begin
		hi_ne = 4'h0;
		for (int q = 0; q < 4; q++) begin
			if (Q_NONEMPTY[q])
				hi_ne = 4'(1 << q);
		end
		for (int q = 0; q < 4; q++) begin
			// Empty queues drop their share; if any queue is empty, the top busy queue takes one more
			if (!need_reload)
				eff_cred[q] = cred_reg[q];
			else if (!Q_NONEMPTY[q])
				eff_cred[q] = 4'h0;
			else
				eff_cred[q] = (sgc_pkg::WFQ_W0 << q) + {3'h0, hi_ne[q] && any_empty};
			elig[q] = Q_NONEMPTY[q] && (eff_cred[q] != 4'h0);
		end
	end

	always_comb begin
		grant = 4'h0;
		for (int q = 0; q < 4; q++) begin
			if (pick[q])
				grant = 4'(1 << q);
		end
		for (int q = 0; q < 4; q++) begin
			if (!CFG.wfq_en)
				cred_next[q] = 4'h0;
			else if (TX_REQ)
				cred_next[q] = eff_cred[q] - {3'h0, grant[q]};
			else
				cred_next[q] = cred_reg[q];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			for (int q = 0; q < 4; q++)
				cred_reg[q] <= 4'h0;
			TX_GRANT <= 4'h0;
		end else begin
			for (int q = 0; q < 4; q++)
				cred_reg[q] <= cred_next[q];
			TX_GRANT <= TX_REQ ? grant : 4'h0;
		end
	end

	// ==========================================================
	// IGMP snooping, sniffing and VID replacement
	logic        sniff_hit;
	logic [11:0] vid_next;

	assign sniff_hit = CFG.sniff_and ? (SNIFF_SRC_HIT && SNIFF_DST_HIT)
		: (SNIFF_SRC_HIT || SNIFF_DST_HIT);
	assign vid_next = (CFG.null_vid_rep && FRM_VID_IN == sgc_pkg::NULL_VID) ? PORT_VID : FRM_VID_IN;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			IGMP_TO_MII  <= 1'b0;
			SNIFF_MIRROR <= 1'b0;
			FRM_VID_OUT  <= 12'h000;
		end else begin
			IGMP_TO_MII  <= IGMP_PKT && CFG.igmp_snoop;
			SNIFF_MIRROR <= sniff_hit;
			FRM_VID_OUT  <= vid_next;
		end
	end

	// ==========================================================
	// Broadcast storm protection
	logic [24:0] per_cnt_reg;
	logic [24:0] per_len;
	logic        period_end;
	logic [10:0] blk_cnt_reg [3];

	assign per_len    = CFG.mii_10bt ? STORM_PER_10_CYC : STORM_PER_100_CYC;
	assign period_end = (per_cnt_reg >= per_len - 25'h0000001);

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST || period_end)
			per_cnt_reg <= 25'h0000000;
		else
			per_cnt_reg <= per_cnt_reg + 25'h0000001;
	end

	for (genvar p = 0; p < 3; p++) begin : g_storm
		logic [10:0] cnt_next;

		assign cnt_next = period_end ? {10'h000, STORM_BLK_STB[p]} :
			(STORM_BLK_STB[p] && blk_cnt_reg[p] != sgc_pkg::THR_MAX) ? blk_cnt_reg[p] + 11'h001 :
			blk_cnt_reg[p];

		always_ff @(posedge REF_CLK) begin
			if (SYS_RST) begin
				blk_cnt_reg[p] <= 11'h000;
				STORM_DROP[p]  <= 1'b0;
			end else begin
				blk_cnt_reg[p] <= cnt_next;
				STORM_DROP[p]  <= (cnt_next >= CFG.storm_thr);
			end
		end
	end

	// ==========================================================
	// Assertions
	a_vlan_write:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		addr_fire && HWRITE && mapped && a_idx == sgc_pkg::IDX_FWD_OPT ##1 1'b1
		|=> CFG.vlan_en == $past(HWDATA[7]))
	else $error("VLAN enable did not follow write");

	a_igmp_fwd:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		1'b1 |=> IGMP_TO_MII == $past(IGMP_PKT && CFG.igmp_snoop))
	else $error("IGMP forward wrong");

	a_wfq_ratio:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		CFG.wfq_en && TX_REQ && need_reload && Q_NONEMPTY == 4'hf
		|=> TX_GRANT == 4'h8 && cred_reg[3] == 4'h7 && cred_reg[2] == 4'h4 && cred_reg[0] == 4'h1)
	else $error("WFQ reload weights wrong");

	a_wfq_bonus:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		CFG.wfq_en && TX_REQ && need_reload && Q_NONEMPTY == 4'hb
		|=> cred_reg[3] == 4'h8 && cred_reg[2] == 4'h0)
	else $error("WFQ empty queue bonus wrong");

	a_strict_prio:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		!CFG.wfq_en && TX_REQ && Q_NONEMPTY[3] |=> TX_GRANT == 4'h8)
	else $error("Strict priority grant wrong");

	a_sniff_and:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		CFG.sniff_and && (SNIFF_SRC_HIT != SNIFF_DST_HIT) && $stable(CFG) |=> !SNIFF_MIRROR)
	else $error("AND sniff mirrored a half match");

	a_sniff_or:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		!CFG.sniff_and && (SNIFF_SRC_HIT || SNIFF_DST_HIT) |=> SNIFF_MIRROR)
	else $error("OR sniff missed a match");

	a_mii_reset:
	assert property (@(posedge REF_CLK)
		SYS_RST |=> CFG.mii_fc && !CFG.mii_half && !CFG.mii_10bt && CFG.storm_thr == 11'h063)
	else $error("MII or threshold reset value wrong");

	a_vid_replace:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		CFG.null_vid_rep && FRM_VID_IN == 12'h000 |=> FRM_VID_OUT == $past(PORT_VID))
	else $error("Null VID not replaced");

	a_storm_clear:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		period_end && STORM_BLK_STB == 3'h0 && CFG.storm_thr != 11'h000 ##1 !wr_mii && !wr_lo
		|-> STORM_DROP == 3'h0)
	else $error("Storm drop not cleared at period end");

	a_mii_write:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		addr_fire && HWRITE && mapped && a_idx == sgc_pkg::IDX_MII_HIGH ##1 1'b1
		|=> {CFG.mii_half, CFG.mii_fc, CFG.mii_10bt, CFG.null_vid_rep, CFG.storm_thr[10:8]}
			== $past(HWDATA[6:0]))
	else $error("MII register write not applied");

	a_lo_write:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		addr_fire && HWRITE && mapped && a_idx == sgc_pkg::IDX_STORM_LO ##1 1'b1
		|=> CFG.storm_thr[7:0] == $past(HWDATA[7:0]))
	else $error("Threshold low byte write not applied");

	a_status_read:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		addr_fire && !HWRITE && mapped && a_idx == sgc_pkg::IDX_STATUS
		|=> HRDATA[3] == $past(CFG.mii_10bt) && HRDATA[2:0] == $past(STORM_DROP))
	else $error("Status read data wrong");

	a_storm_hold:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		STORM_DROP[0] && !period_end && $stable(CFG.storm_thr) |=> STORM_DROP[0])
	else $error("Storm drop released inside a period");

	a_grant_busy:
	assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		TX_REQ |=> $onehot0(TX_GRANT) && (TX_GRANT & ~$past(Q_NONEMPTY)) == 4'h0)
	else $error("Grant to an idle queue");

	c_wfq_bonus:  cover property (@(posedge REF_CLK) CFG.wfq_en && need_reload && Q_NONEMPTY == 4'hb);
	c_storm_drop: cover property (@(posedge REF_CLK) STORM_DROP != 3'h0);
	c_sniff_and:  cover property (@(posedge REF_CLK) CFG.sniff_and && SNIFF_MIRROR);
	c_reg_read:   cover property (@(posedge REF_CLK) addr_fire && !HWRITE && a_idx == sgc_pkg::IDX_STATUS);

endmodule

// ==== hdl/sgc_pkg.sv ====
package sgc_pkg;

	// ==========================================================
	// Clock and storm period timing
	localparam int unsigned CLK_KHZ          = 50000;
	localparam int unsigned STORM_PER_100_MS = 67;
	localparam int unsigned STORM_PER_10_MS  = 500;
	localparam logic [24:0] STORM_PER_100_CYC = 25'(STORM_PER_100_MS * CLK_KHZ);
	localparam logic [24:0] STORM_PER_10_CYC  = 25'(STORM_PER_10_MS * CLK_KHZ);

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] IDX_FWD_OPT  = 8'h05;
	localparam logic [7:0] IDX_MII_HIGH = 8'h06;
	localparam logic [7:0] IDX_STORM_LO = 8'h07;
	localparam logic [7:0] IDX_STATUS   = 8'h40;

	// ==========================================================
	// Reset values and writable masks
	localparam logic [7:0] RST_FWD_OPT   = 8'h00;
	localparam logic [7:0] RST_MII_HIGH  = 8'h20;
	localparam logic [7:0] RST_STORM_LO  = 8'h63;
	localparam logic [7:0] WMASK_FWD_OPT  = 8'hc9;
	localparam logic [7:0] WMASK_MII_HIGH = 8'h7f;

	// ==========================================================
	// Field positions
	localparam int unsigned B_VLAN_EN    = 7;
	localparam int unsigned B_IGMP_SNOOP = 6;
	localparam int unsigned B_WFQ_EN     = 3;
	localparam int unsigned B_SNIFF_AND  = 0;
	localparam int unsigned B_MII_HALF   = 6;
	localparam int unsigned B_MII_FC     = 5;
	localparam int unsigned B_MII_10BT   = 4;
	localparam int unsigned B_NULL_VID   = 3;
	localparam int unsigned B_THR_HI_MSB = 2;

	// ==========================================================
	// Misc constants
	localparam logic [3:0]  WFQ_W0   = 4'h1;
	localparam logic [11:0] NULL_VID = 12'h000;
	localparam logic [10:0] THR_MAX  = 11'h7ff;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

	typedef struct packed {
		logic        vlan_en;
		logic        igmp_snoop;
		logic        wfq_en;
		logic        sniff_and;
		logic        mii_half;
		logic        mii_fc;
		logic        mii_10bt;
		logic        null_vid_rep;
		logic [10:0] storm_thr;
	} sgc_cfg_s;

endpackage

// ==== dv/sgc_host_model.sv ====
`timescale 1ns/1ps
module sgc_host_model (
	// Clock and bus answer
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// Bus request
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	initial begin
		hsel   = 1'b0;
		haddr  = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0;
	end

	// ==========================================================
	// Single word transfer, entered right after a rising edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		htrans <= sgc_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		// Released data lines show garbage, not the last value
		hwdata <= ~{24'h0, wd};
	endtask
endmodule

// ==== dv/switch_global_control_3_4_tb.sv ====
`timescale 1ns/1ps
module switch_global_control_3_4_tb;
	localparam logic [24:0] P100 = 25'h0000028;
	localparam logic [24:0] P10  = 25'h00000c8;
	localparam logic [7:0]  FWD  = sgc_pkg::IDX_FWD_OPT;
	localparam logic [7:0]  MII  = sgc_pkg::IDX_MII_HIGH;
	localparam logic [7:0]  SLO  = sgc_pkg::IDX_STORM_LO;
	logic              ref_clk  = 1'b0;
	logic              sys_rst  = 1'b1;
	logic              tx_req   = 1'b0;
	logic              igmp_pkt = 1'b0;
	logic              src_hit  = 1'b0;
	logic              dst_hit  = 1'b0;
	logic [2:0]        stb      = 3'h0;
	logic [3:0]        q_ne     = 4'h0;
	logic [11:0]       vid_in   = 12'h0;
	logic [11:0]       port_vid = 12'h0;
	logic              hsel, hwrite, hreadyout, hresp, igmp_mii, mirror;
	logic [31:0]       haddr, hwdata, hrdata;
	logic [1:0]        htrans;
	logic [2:0]        hsize, drop;
	logic [3:0]        grant;
	logic [11:0]       vid_out;
	sgc_pkg::sgc_cfg_s cfg;
	int                num_errors = 0;
	int                num_checks = 0;
	int                cycles = 0;
	int                gcnt[4];

	always #10 ref_clk = ~ref_clk;

	sgc_host_model sgc_host_model_i (.clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	sgc_global_ctrl #(.STORM_PER_100_CYC(P100), .STORM_PER_10_CYC(P10)) sgc_global_ctrl_i (
		.REF_CLK(ref_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .CFG(cfg), .Q_NONEMPTY(q_ne), .TX_REQ(tx_req), .TX_GRANT(grant),
		.IGMP_PKT(igmp_pkt), .IGMP_TO_MII(igmp_mii), .SNIFF_SRC_HIT(src_hit), .SNIFF_DST_HIT(dst_hit),
		.SNIFF_MIRROR(mirror), .FRM_VID_IN(vid_in), .PORT_VID(port_vid), .FRM_VID_OUT(vid_out),
		.STORM_BLK_STB(stb), .STORM_DROP(drop));

	// ==========================================================
	// Checking and bus helpers
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic [31:0] d;
		sgc_host_model_i.xfer(1'b1, idx, v, d);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		sgc_host_model_i.xfer(1'b0, idx, 8'h00, d);
		chk($sformatf("reg %h", idx), d, exp);
		chk("resp", hresp, 32'h0);
	endtask

	task automatic step;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic sched(input logic [3:0] ne, input int n);
		gcnt = '{4{0}};
		q_ne   <= ne;
		tx_req <= 1'b1;
		repeat (n) begin
			step();
			for (int q = 0; q < 4; q++) if (grant[q] === 1'b1) gcnt[q]++;
		end
		tx_req <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic gap(output int n);
		logic p;
		n = 0;
		do begin
			p = drop[0];
			step();
			n++;
		end while (!(p === 1'b1 && drop[0] === 1'b0));
	endtask

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			close_out();
		end
	end

	// ==========================================================
	// Test sequence
	initial begin
		int n;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		step();
		chk("fc", cfg.mii_fc, 32'h1);
		chk("thr", cfg.storm_thr, 32'h063);
		rdchk(FWD, 32'h00);
		rdchk(MII, 32'h20);
		rdchk(SLO, 32'h63);
		wr(8'h0c, 8'h5a);
		rdchk(8'h0c, 32'h0);
		wr(FWD, 8'hc9);
		rdchk(FWD, 32'hc9);
		chk("vlan", cfg.vlan_en, 32'h1);
		wr(MII, 8'h7f);
		rdchk(MII, 32'h7f);
		chk("half", cfg.mii_half, 32'h1);
		chk("10bt", cfg.mii_10bt, 32'h1);
		chk("thr", cfg.storm_thr, 32'h763);
		vid_in   <= 12'h000;
		port_vid <= 12'h5a5;
		step();
		chk("vid", vid_out, 32'h5a5);
		vid_in <= 12'h123;
		step();
		chk("vid", vid_out, 32'h123);
		wr(MII, 8'h20);
		vid_in <= 12'h000;
		step();
		chk("vid", vid_out, 32'h000);
		chk("half", cfg.mii_half, 32'h0);
		for (int m = 0; m < 2; m++) begin
			wr(FWD, m[0] ? 8'h41 : 8'h00);
			igmp_pkt <= 1'b1;
			@(posedge ref_clk);
			igmp_pkt <= 1'b0;
			#1;
			chk("igmp", igmp_mii, 32'(m));
			chk("vlan", cfg.vlan_en, 32'h0);
			for (int s = 0; s < 4; s++) begin
				{src_hit, dst_hit} <= 2'(s);
				step();
				chk("sniff", mirror, m[0] ? 32'(s == 3) : 32'(s != 0));
			end
		end
		wr(FWD, 8'h08);
		sched(4'hf, 15);
		chk("wfq", {gcnt[3][7:0], gcnt[2][7:0], gcnt[1][7:0], gcnt[0][7:0]}, 32'h08040201);
		sched(4'hb, 12);
		chk("wfq", {gcnt[3][7:0], gcnt[2][7:0], gcnt[1][7:0], gcnt[0][7:0]}, 32'h09000201);
		wr(FWD, 8'h00);
		sched(4'h6, 3);
		chk("prio", {gcnt[3][7:0], gcnt[2][7:0], gcnt[1][7:0], gcnt[0][7:0]}, 32'h00030000);
		sched(4'he, 2);
		chk("prio", {gcnt[3][7:0], gcnt[2][7:0], gcnt[1][7:0], gcnt[0][7:0]}, 32'h02000000);
		wr(SLO, 8'h02);
		stb <= 3'b101;
		gap(n);
		gap(n);
		chk("per100", 32'(n), 32'(P100));
		step();
		chk("drop", drop, 32'h5);
		rdchk(8'h40, 32'h05);
		wr(MII, 8'h30);
		gap(n);
		gap(n);
		chk("per10", 32'(n), 32'(P10));
		rdchk(8'h40, 32'h08);
		stb     <= 3'b000;
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		step();
		chk("fc", cfg.mii_fc, 32'h1);
		chk("drop", drop, 32'h0);
		rdchk(MII, 32'h20);
		rdchk(SLO, 32'h63);
		close_out();
	end
endmodule
